// ### fanout_model.sv
`timescale 1ns/1ns
module fanout_model (
	input  wire logic                        clk,
	input  wire store_check_pkg::memCmd_type memCmd,
	input  wire logic [25:0]                 wrEven,
	input  wire logic [25:0]                 wrOdd,
	input  wire logic [7:0]                  equipped,
	input  wire logic [7:0]                  refFlip,
	input  wire logic [7:0]                  selFlip,
	input  wire logic [2:0]                  timFlip,
	output logic [7:0]                       refSelRet,
	output logic [7:0]                       modSelRet,
	output logic [7:0]                       addrParErr,
	output logic [2:0]                       timingRet,
	output logic [25:0]                      rdEven,
	output logic [25:0]                      rdOdd
);
	logic [25:0] mem [4096];
	logic [11:0] idx;
	logic        odd;
	logic        rd;
	initial foreach (mem[i]) mem[i] = 26'h0000000;
	// small window of each module only: enough for a few words per test
	assign idx = {memCmd.sel, memCmd.addr[3:0]};
	assign odd = |(memCmd.sel & 8'haa);
	assign rd  = (memCmd.sel != 8'h00) && !memCmd.write && !memCmd.refresh;
	// all equipped boards answer a refresh together
	assign refSelRet  = (memCmd.refresh ? equipped : 8'h00) ^ refFlip;
	// only the selected equipped module answers
	assign modSelRet  = (memCmd.refresh ? 8'h00 : memCmd.sel & equipped) ^ selFlip;
	// odd parity over the module address
	assign addrParErr = (memCmd.addrPar == ~^memCmd.addr) ? 8'h00 : memCmd.sel & equipped;
	assign timingRet  = memCmd.timing ^ timFlip;
	// idle data lines show the inverse, so a stale capture cannot pass
	assign rdEven = (rd && !odd) ? mem[idx] : ~mem[idx];
	assign rdOdd  = (rd && odd) ? mem[idx] : ~mem[idx];
	always @(posedge clk)
		if (memCmd.write && memCmd.sel != 8'h00)
			mem[idx] <= odd ? wrOdd : wrEven;
endmodule

// ### store_check.sv
// Functional notes
// - commands are two-of-four codes and a valid code raises no error.
// - a received address is returned to the processor by the echo command.
// - the echo command loops data back and flags deliberately bad data parity.
// - data word parity is checked and parity and error answers follow the data received.
// - a refresh drives all modules at once and each equipped fanout returns refresh select.
// - a refresh-select return stuck active or stuck inactive on an equipped board is flagged.
// - a normal access selects one module and errs unless exactly that module answers.
// - address parity is sent to the fanout boards and any parity error they report is flagged.
// - looped-back timing signals are compared with those expected and missing ones flagged.
// - four 16-bit guard registers, bitwise writable and readable by maintenance commands only.
// - a normal write into a guarded region or with bad data parity is suppressed, otherwise it is performed.
// - requests are accepted from the standby processor's bus port when it is selected.
// - even and odd modules have separate write and read data paths through registers.
`timescale 1ns/1ns
module store_check (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic                        clkEn,
	input  wire logic                        useStandby,
	input  wire logic                        reqValidOwn,
	input  wire store_check_pkg::busReq_type reqOwn,
	input  wire logic                        reqValidStby,
	input  wire store_check_pkg::busReq_type reqStby,
	output logic                             reqReady,
	output logic                             respValid,
	output store_check_pkg::busResp_type     resp,
	input  wire logic [7:0]                  equipped,
	input  wire logic [7:0]                  refSelRet,
	input  wire logic [7:0]                  modSelRet,
	input  wire logic [7:0]                  addrParErr,
	input  wire logic [2:0]                  timingRet,
	input  wire logic [25:0]                 rdEven,
	input  wire logic [25:0]                 rdOdd,
	output store_check_pkg::memCmd_type      memCmd,
	output logic [25:0]                      wrEven,
	output logic [25:0]                      wrOdd
);

	function automatic logic legalCmd(input logic [3:0] c);
		return ($countones(c) == 2);
	endfunction

	function automatic logic [1:0] genPar(input logic [23:0] d);
		return {~^d[23:12], ~^d[11:0]};
	endfunction

	function automatic logic [2:0] timingFor(input logic [3:0] c);
		case (c)
			store_check_pkg::CMD_READ:    return store_check_pkg::TIM_READ;
			store_check_pkg::CMD_WRITE:   return store_check_pkg::TIM_WRITE;
			store_check_pkg::CMD_REFRESH: return store_check_pkg::TIM_REFRESH;
			default:                      return 3'h0;
		endcase
	endfunction

	store_check_pkg::state_type    state_ff,  nxt_state;
	store_check_pkg::busReq_type   req_ff,    nxt_req;
	store_check_pkg::busResp_type  resp_ff,   nxt_resp;
	store_check_pkg::memCmd_type   mem_ff,    nxt_mem;
	logic [3:0][15:0]              guard_ff,  nxt_guard;
	logic                          ready_ff,  nxt_ready;
	logic                          rvalid_ff, nxt_rvalid;
	logic [25:0]                   wrEven_ff, nxt_wrEven;
	logic [25:0]                   wrOdd_ff,  nxt_wrOdd;

	store_check_pkg::busReq_type   req;
	logic                          reqV;
	logic [5:0]                    block;
	logic                          prot;
	logic                          dataOk;
	logic                          memOp;
	logic [2:0]                    modNum;

	always_comb begin
		req = useStandby ? reqStby : reqOwn;
		reqV = useStandby ? reqValidStby : reqValidOwn;
		nxt_state = state_ff;
		nxt_req = req_ff;
		nxt_resp = resp_ff;
		nxt_mem = '0;
		nxt_guard = guard_ff;
		nxt_rvalid = 1'b0;
		nxt_wrEven = '0;
		nxt_wrOdd = '0;
		block = '0;
		prot = 1'b0;
		dataOk = 1'b0;
		memOp = 1'b0;
		modNum = '0;
		case (state_ff)
			store_check_pkg::ST_IDLE: begin
				// nothing is taken until ready shows, so the edge right after reset refuses
				if (reqV && ready_ff) begin
					nxt_req = req;
					block = req.addr[17:store_check_pkg::BLOCK_LSB];
					prot = guard_ff[block[5:4]][block[3:0]];
					dataOk = (genPar(req.data) == req.par);
					modNum = req.addr[17:store_check_pkg::MOD_LSB];
					if (req.cmd == store_check_pkg::CMD_READ || req.cmd == store_check_pkg::CMD_WRITE)
						nxt_mem.sel = 8'h01 << modNum;
					nxt_mem.refresh = (req.cmd == store_check_pkg::CMD_REFRESH);
					nxt_mem.write = (req.cmd == store_check_pkg::CMD_WRITE) && !prot && dataOk;
					memOp = nxt_mem.refresh || (|nxt_mem.sel);
					if (memOp) begin
						nxt_mem.addr = req.addr[14:0];
						// parity covers only the bits the fanout boards receive
						nxt_mem.addrPar = ~^req.addr[14:0] ^
							req.ctl[store_check_pkg::CTL_BAD_APAR];
						// inhibit lets the loop-back check be proven
						nxt_mem.timing = req.ctl[store_check_pkg::CTL_NO_TIMING]
							? 3'h0 : timingFor(req.cmd);
					end
					if (nxt_mem.write) begin
						if (modNum[0])
							nxt_wrOdd = {req.par, req.data};
						else
							nxt_wrEven = {req.par, req.data};
					end
					nxt_state = store_check_pkg::ST_ACCESS;
				end
			end
			store_check_pkg::ST_ACCESS: begin
				block = req_ff.addr[17:store_check_pkg::BLOCK_LSB];
				prot = guard_ff[block[5:4]][block[3:0]];
				dataOk = (genPar(req_ff.data) == req_ff.par);
				memOp = mem_ff.refresh || (|mem_ff.sel);
				nxt_resp = '0;
				nxt_resp.err[store_check_pkg::ERR_CMD] = !legalCmd(req_ff.cmd);
				nxt_resp.err[store_check_pkg::ERR_DPAR] = !dataOk &&
					(req_ff.cmd == store_check_pkg::CMD_WRITE ||
					 req_ff.cmd == store_check_pkg::CMD_MWRITE ||
					 req_ff.cmd == store_check_pkg::CMD_ECHO);
				// refresh: every equipped board must answer; otherwise no equipped board may
				nxt_resp.err[store_check_pkg::ERR_REFSEL] = mem_ff.refresh
					? ((refSelRet & equipped) != equipped)
					: (|(refSelRet & equipped));
				nxt_resp.err[store_check_pkg::ERR_MODSEL] = !mem_ff.refresh &&
					(modSelRet != mem_ff.sel);
				nxt_resp.err[store_check_pkg::ERR_APAR] = memOp &&
					(|(addrParErr & equipped));
				nxt_resp.err[store_check_pkg::ERR_TIMING] = memOp &&
					(timingRet != timingFor(req_ff.cmd));
				nxt_resp.err[store_check_pkg::ERR_PROT] =
					(req_ff.cmd == store_check_pkg::CMD_WRITE) && prot;
				case (req_ff.cmd)
					store_check_pkg::CMD_READ: begin
						{nxt_resp.par, nxt_resp.data} =
							req_ff.addr[store_check_pkg::MOD_LSB] ? rdOdd : rdEven;
					end
					store_check_pkg::CMD_MREAD: begin
						nxt_resp.data = {8'h00, guard_ff[req_ff.addr[1:0]]};
						nxt_resp.par = genPar(nxt_resp.data);
					end
					store_check_pkg::CMD_ECHO: begin
						nxt_resp.addr = req_ff.addr;
						nxt_resp.data = req_ff.data;
						nxt_resp.par = req_ff.par;
					end
					store_check_pkg::CMD_MWRITE: begin
						// bad parity leaves the guard bits untouched
						if (dataOk)
							nxt_guard[req_ff.addr[1:0]] = req_ff.data[15:0];
					end
					default: begin
					end
				endcase
				nxt_rvalid = 1'b1;
				nxt_state = store_check_pkg::ST_IDLE;
			end
			default: nxt_state = store_check_pkg::ST_IDLE;
		endcase
		nxt_ready = (nxt_state == store_check_pkg::ST_IDLE);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= store_check_pkg::ST_IDLE;
			req_ff <= '0;
			resp_ff <= '0;
			mem_ff <= '0;
			guard_ff <= {4{store_check_pkg::GUARD_RST}};
			ready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			wrEven_ff <= '0;
			wrOdd_ff <= '0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			req_ff <= nxt_req;
			resp_ff <= nxt_resp;
			mem_ff <= nxt_mem;
			guard_ff <= nxt_guard;
			ready_ff <= nxt_ready;
			rvalid_ff <= nxt_rvalid;
			wrEven_ff <= nxt_wrEven;
			wrOdd_ff <= nxt_wrOdd;
		end
	end

	assign reqReady = ready_ff;
	assign respValid = rvalid_ff;
	assign resp = resp_ff;
	assign memCmd = mem_ff;
	assign wrEven = wrEven_ff;
	assign wrOdd = wrOdd_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	chk_cmd_code_err: assert property (respValid |->
		resp.err[store_check_pkg::ERR_CMD] == ($countones(req_ff.cmd) != 2))
		else $error("command code error flag wrong");
	chk_addr_echo: assert property (respValid && req_ff.cmd == store_check_pkg::CMD_ECHO
		|-> resp.addr == req_ff.addr && resp.data == req_ff.data)
		else $error("echo did not return address and data");
	chk_echo_par_err: assert property (respValid && req_ff.cmd == store_check_pkg::CMD_ECHO
		|-> resp.err[store_check_pkg::ERR_DPAR] == (genPar(req_ff.data) != req_ff.par))
		else $error("echo parity error flag wrong");
	chk_write_guard: assert property (mem_ff.write |->
		!guard_ff[req_ff.addr[17:16]][req_ff.addr[15:12]] &&
		genPar(req_ff.data) == req_ff.par)
		else $error("write issued into guarded block");
	chk_modsel_err: assert property (state_ff == store_check_pkg::ST_ACCESS && clkEn &&
		|mem_ff.sel && modSelRet != mem_ff.sel |=> resp.err[store_check_pkg::ERR_MODSEL])
		else $error("module select mismatch not flagged");
	chk_refsel_stuck: assert property (state_ff == store_check_pkg::ST_ACCESS && clkEn &&
		mem_ff.refresh && (refSelRet & equipped) != equipped
		|=> resp.err[store_check_pkg::ERR_REFSEL])
		else $error("missing refresh select not flagged");
	chk_timing_loop: assert property (state_ff == store_check_pkg::ST_ACCESS && clkEn &&
		mem_ff.refresh && timingRet != store_check_pkg::TIM_REFRESH
		|=> resp.err[store_check_pkg::ERR_TIMING])
		else $error("timing loop-back fault not flagged");
	chk_apar_err: assert property (state_ff == store_check_pkg::ST_ACCESS && clkEn &&
		|mem_ff.sel && |(addrParErr & equipped) |=> resp.err[store_check_pkg::ERR_APAR])
		else $error("address parity report not flagged");
	chk_guard_write: assert property (state_ff == store_check_pkg::ST_ACCESS && clkEn &&
		req_ff.cmd == store_check_pkg::CMD_MWRITE && genPar(req_ff.data) == req_ff.par
		|=> guard_ff[$past(req_ff.addr[1:0])] == $past(req_ff.data[15:0]))
		else $error("guard register not written");
	chk_even_odd: assert property (mem_ff.write |->
		(req_ff.addr[15] ? (wrEven == 26'h0 && wrOdd == {req_ff.par, req_ff.data})
		: (wrOdd == 26'h0 && wrEven == {req_ff.par, req_ff.data})))
		else $error("write data on wrong module path");
	chk_one_cycle: assert property (reqReady && clkEn &&
		(useStandby ? reqValidStby : reqValidOwn) |=> !reqReady ##1 respValid || !clkEn)
		else $error("request not answered in one access");

	cov_refresh: cover property (respValid && req_ff.cmd == store_check_pkg::CMD_REFRESH);
	cov_prot_write: cover property (respValid && resp.err[store_check_pkg::ERR_PROT]);
	cov_standby: cover property (reqReady && clkEn && useStandby && reqValidStby);

endmodule

// ### store_check_pkg.sv
package store_check_pkg;

	// two-of-four command codes
	localparam logic [3:0] CMD_READ    = 4'h3;
	localparam logic [3:0] CMD_WRITE   = 4'h5;
	localparam logic [3:0] CMD_MWRITE  = 4'h6;
	localparam logic [3:0] CMD_MREAD   = 4'h9;
	localparam logic [3:0] CMD_ECHO    = 4'ha;
	localparam logic [3:0] CMD_REFRESH = 4'hc;

	// error vector bit positions
	localparam int ERR_CMD    = 0;
	localparam int ERR_DPAR   = 1;
	localparam int ERR_REFSEL = 2;
	localparam int ERR_MODSEL = 3;
	localparam int ERR_APAR   = 4;
	localparam int ERR_TIMING = 5;
	localparam int ERR_PROT   = 6;

	// control field bit positions
	localparam int CTL_BAD_APAR  = 0;
	localparam int CTL_NO_TIMING = 1;

	// address fields: module, 4k-word block, guard register select
	localparam int MOD_LSB   = 15;
	localparam int BLOCK_LSB = 12;

	// timing signal patterns sent to the fanout boards
	localparam logic [2:0] TIM_READ    = 3'h3;
	localparam logic [2:0] TIM_WRITE   = 3'h7;
	localparam logic [2:0] TIM_REFRESH = 3'h1;

	localparam logic [15:0] GUARD_RST = 16'h0000;

	typedef enum {ST_IDLE, ST_ACCESS} state_type;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [17:0] addr;
		logic [23:0] data;
		logic [1:0]  par;
		logic [1:0]  ctl;
	} busReq_type;

	typedef struct packed {
		logic [17:0] addr;
		logic [23:0] data;
		logic [1:0]  par;
		logic [7:0]  err;
	} busResp_type;

	typedef struct packed {
		logic [7:0]  sel;
		logic        refresh;
		logic        write;
		logic [14:0] addr;
		logic        addrPar;
		logic [2:0]  timing;
	} memCmd_type;

endpackage

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
	localparam logic [3:0] CMDS [6] = '{store_check_pkg::CMD_READ, store_check_pkg::CMD_WRITE,
		store_check_pkg::CMD_MWRITE, store_check_pkg::CMD_MREAD, store_check_pkg::CMD_ECHO,
		store_check_pkg::CMD_REFRESH};
	logic                         clk, rstn, clkEn, useStandby, reqValidOwn, reqValidStby;
	logic                         reqReady, respValid;
	store_check_pkg::busReq_type  reqOwn, reqStby;
	store_check_pkg::busResp_type resp;
	store_check_pkg::memCmd_type  memCmd;
	logic [7:0]                   equipped, refSelRet, modSelRet, addrParErr, refFlip, selFlip;
	logic [2:0]                   timingRet, timFlip;
	logic [25:0]                  rdEven, rdOdd, wrEven, wrOdd;
	int                           mismatches = 0;
	int                           cmpCount = 0;

	store_check u_dut (.clk(clk), .rstn(rstn), .clkEn(clkEn), .useStandby(useStandby),
		.reqValidOwn(reqValidOwn), .reqOwn(reqOwn), .reqValidStby(reqValidStby),
		.reqStby(reqStby), .reqReady(reqReady), .respValid(respValid), .resp(resp),
		.equipped(equipped), .refSelRet(refSelRet), .modSelRet(modSelRet),
		.addrParErr(addrParErr), .timingRet(timingRet), .rdEven(rdEven), .rdOdd(rdOdd),
		.memCmd(memCmd), .wrEven(wrEven), .wrOdd(wrOdd));
	fanout_model u_fanout (.clk(clk), .memCmd(memCmd), .wrEven(wrEven), .wrOdd(wrOdd),
		.equipped(equipped), .refFlip(refFlip), .selFlip(selFlip), .timFlip(timFlip),
		.refSelRet(refSelRet), .modSelRet(modSelRet), .addrParErr(addrParErr),
		.timingRet(timingRet), .rdEven(rdEven), .rdOdd(rdOdd));

	always #25 clk = ~clk;

	function automatic logic [1:0] par(input logic [23:0] d);
		return {~^d[23:12], ~^d[11:0]};
	endfunction

	task automatic end_sim();
		if (mismatches == 0 && cmpCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// the unselected port carries a different live request, so a wrong port pick shows
	task automatic op(input logic [3:0] cmd, input logic [17:0] addr, input logic [23:0] data,
			input logic [1:0] ctl, input logic [1:0] pf, input logic [7:0] expErr);
		store_check_pkg::busReq_type rq, nq;
		int n;
		rq = {cmd, addr, data, par(data) ^ pf, ctl};
		nq = ~rq;
		n = 0;
		@(negedge clk);
		reqOwn = useStandby ? nq : rq;
		reqStby = useStandby ? rq : nq;
		reqValidOwn = 1'b1;
		reqValidStby = 1'b1;
		while (reqReady !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		reqValidOwn = 1'b0;
		reqValidStby = 1'b0;
		while (respValid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20) begin
			mismatches++;
			end_sim();
		end else begin
			check(resp.err, expErr);
		end
	endtask

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		clkEn = 1'b1;
		useStandby = 1'b0;
		reqValidOwn = 1'b0;
		reqValidStby = 1'b0;
		reqOwn = '0;
		reqStby = '0;
		equipped = 8'hff;
		refFlip = 8'h00;
		selFlip = 8'h00;
		timFlip = 3'h0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		foreach (CMDS[i]) op(CMDS[i], 18'h00010, 24'h000000, 2'h0, 2'h0, 8'h00);
		op(4'h7, 18'h00010, 24'h000000, 2'h0, 2'h0, 8'h01);
		op(4'h0, 18'h00010, 24'h000000, 2'h0, 2'h0, 8'h01);
		op(CMDS[4], 18'h2a5c3, 24'hc3a55a, 2'h0, 2'h0, 8'h00);
		check(resp.addr, 18'h2a5c3);
		check(resp.data, 24'hc3a55a);
		check(resp.par, par(24'hc3a55a));
		op(CMDS[4], 18'h2a5c3, 24'hc3a55a, 2'h0, 2'h2, 8'h02);
		op(CMDS[1], 18'h0000a, 24'h123456, 2'h0, 2'h1, 8'h02);
		for (int m = 0; m < 2; m++) begin
			if (equipped[m]) begin
				op(CMDS[1], {m[2:0], 15'h0003}, 24'h3c0f00 + m, 2'h0, 2'h0, 8'h00);
				op(CMDS[0], {m[2:0], 15'h0003}, 24'h000000, 2'h0, 2'h0, 8'h00);
				check(resp.data, 24'h3c0f00 + m);
				check(resp.par, par(24'h3c0f00 + m));
			end
		end
		refFlip = 8'h04;
		op(CMDS[5], 18'h00000, 24'h000000, 2'h0, 2'h0, 8'h04); // stuck inactive
		op(CMDS[0], 18'h00001, 24'h000000, 2'h0, 2'h0, 8'h04); // stuck active
		refFlip = 8'h00;
		selFlip = 8'h10;
		op(CMDS[0], 18'h00001, 24'h000000, 2'h0, 2'h0, 8'h08);
		selFlip = 8'h00;
		equipped = 8'h0f;
		op(CMDS[0], 18'h28000, 24'h000000, 2'h0, 2'h0, 8'h08);
		equipped = 8'hff;
		op(CMDS[0], 18'h00005, 24'h000000, 2'h1, 2'h0, 8'h10);
		op(CMDS[0], 18'h00005, 24'h000000, 2'h2, 2'h0, 8'h20);
		timFlip = 3'h2;
		op(CMDS[1], 18'h00006, 24'h000000, 2'h0, 2'h0, 8'h20);
		timFlip = 3'h0;
		op(CMDS[3], 18'h00003, 24'h000000, 2'h0, 2'h0, 8'h00);
		check(resp.data[15:0], store_check_pkg::GUARD_RST);
		for (int r = 0; r < 4; r++) begin
			op(CMDS[2], r, 24'h000001 << (4 * r), 2'h0, 2'h0, 8'h00);
			op(CMDS[3], r, 24'h000000, 2'h0, 2'h0, 8'h00);
			check(resp.data[15:0], 16'h0001 << (4 * r));
		end
		// guard reg 1 bit 4 now covers block 0x14 only
		op(CMDS[1], 18'h14007, 24'h0abcde, 2'h0, 2'h0, 8'h40);
		op(CMDS[0], 18'h14007, 24'h000000, 2'h0, 2'h0, 8'h00);
		check(resp.data, 24'h000000);
		op(CMDS[1], 18'h15008, 24'h0abcde, 2'h0, 2'h0, 8'h00);
		op(CMDS[0], 18'h15008, 24'h000000, 2'h0, 2'h0, 8'h00);
		check(resp.data, 24'h0abcde);
		useStandby = 1'b1;
		op(CMDS[4], 18'h1b2c4, 24'h5a0ff0, 2'h0, 2'h0, 8'h00);
		check(resp.data, 24'h5a0ff0);
		end_sim();
	end
endmodule
